// ---- hdl/ats_params.svh ----
// Constants of the antenna tuner sequencer: widths, offsets, resets, timing
// Functional notes
// R1: Magnitude input high means antenna impedance above 50 ohm, low means below.
// R2: Phase input high means inductive antenna, low means capacitive.
// R3: Raise ready once reflected level falls below the configured threshold.
// R4: Capacitive antenna: step inductors up from smallest until phase turns inductive, sample magnitude.
// R5: After inductor sweep: below 50 ohm match with tx-side caps, above with antenna-side.
// R6: Inductive antenna: step antenna-side caps up until capacitive, then choose bank by magnitude.
// R7: Tx-side capacitor bank is 8 relay bits, 30 pF to 3800 pF, LED each.
// R8: Inductor bank is 11 relay bits of doubling weight from smallest element, LED each.
// R9: Antenna-side capacitor bank is 7 relay bits, 15 pF to 960 pF, LED each.
// R10: Tune request goes to the sequencer; key drives the antenna relay directly.
// R11: Attenuator is inserted in the transmit path while tuning runs.
// R12: Fault output whenever a supply rail is bad or power switch is off.
// R13: Manual switch raises manual output and banks follow the local switches.
// R14: Local exciter-retune switch is passed on to the main unit.
// R15: Main unit starts matching by driving the tune request.
// R16: Ready drops when a new tune request begins, stays low until done.
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH
`define ATS_CA_W 8
`define ATS_L_W 11
`define ATS_CB_W 7
`define ATS_ADDR_W 8
`define ATS_OFS_THRESH 8'h00
`define ATS_OFS_STATUS 8'h04
`define ATS_OFS_IRQ_STAT 8'h08
`define ATS_OFS_IRQ_MASK 8'h0C
`define ATS_OFS_BANKS 8'h10
`define ATS_RST_THRESH 8'h10
`define ATS_RST_MASK 4'h0
`define ATS_IRQ_DONE 0
`define ATS_IRQ_FAIL 1
`define ATS_IRQ_FAULT 2
`define ATS_IRQ_MANUAL 3
`define ATS_CLK_MHZ 20
`define ATS_SETTLE_US 5000
`define ATS_SETTLE_CYC (`ATS_SETTLE_US * `ATS_CLK_MHZ)
`endif

// ---- hdl/ats_pkg.sv ----
// Types of the antenna tuner sequencer
package ats_pkg;
    // Gray coded along idle-start-sweep-match-done
    typedef enum logic [2:0] {
        ATS_IDLE = 3'h0,
        ATS_START = 3'h1,
        ATS_SWEEP = 3'h3,
        ATS_MATCH = 3'h2,
        ATS_DONE = 3'h6,
        ATS_FAIL = 3'h7
    } ats_state_t;
endpackage : ats_pkg

// ---- hdl/ats_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ats_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // Chain; only stage two reads stage one
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
        end
    end
endmodule : ats_sync
`default_nettype wire

// ---- hdl/ats_top.sv ----
// Antenna tuner sequencer: relay bank stepping, link lines, register port
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"
module ats_top
    import ats_pkg::*;
#(
    parameter int SETTLE_CYC = `ATS_SETTLE_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic tune_in,
    input wire logic key_in,
    input wire logic mag_above_in,
    input wire logic phase_ind_in,
    input wire logic manual_sw,
    input wire logic rail12_ok,
    input wire logic rail5_ok,
    input wire logic pwr_sw_on,
    input wire logic retune_sw,
    input wire logic [`ATS_CA_W-1:0] man_ca_sw,
    input wire logic [`ATS_L_W-1:0] man_l_sw,
    input wire logic [`ATS_CB_W-1:0] man_cb_sw,
    input wire logic [7:0] refl_level,
    input wire logic [`ATS_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    output logic ready_out,
    output logic fault_out,
    output logic manual_out,
    output logic exciter_retune,
    output logic ant_relay,
    output logic atten_on,
    output logic [`ATS_CA_W-1:0] tx_side_cond_bank,
    output logic [`ATS_L_W-1:0] inductor_bank,
    output logic [`ATS_CB_W-1:0] antenna_side_cond_bank,
    output logic irq
);
    logic [34:0] sync_q;
    logic tune_s, key_s, mag_s, phase_s, manual_s;
    logic r12_bad_s, r5_bad_s, pwr_off_s, retune_s;
    logic [`ATS_CA_W-1:0] man_ca_s;
    logic [`ATS_L_W-1:0] man_l_s;
    logic [`ATS_CB_W-1:0] man_cb_s;
    logic tune_d_reg, tune_rise, fault_d_reg, manual_d_reg;
    ats_state_t state_reg;
    logic [`ATS_CA_W-1:0] ca_reg;
    logic [`ATS_L_W-1:0] l_reg;
    logic [`ATS_CB_W-1:0] cb_reg;
    logic sweep_l_reg, start_ph_reg, use_cb_reg, kick_reg;
    logic done_p_reg, fail_p_reg;
    logic [23:0] cnt_reg;
    logic settled;
    logic [7:0] thresh_reg;
    logic [3:0] irq_stat_reg, irq_mask_reg, irq_ev, irq_clr;
    logic fault_next;

    // All pin inputs except refl_level pass the three-stage synchroniser
    // Rail and power lines enter inverted, so the zero reset of the chain reads healthy and no false fault follows reset
    ats_sync #(
        .W(35)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({tune_in, key_in, mag_above_in, phase_ind_in, manual_sw, ~rail12_ok, ~rail5_ok,
            ~pwr_sw_on, retune_sw, man_ca_sw, man_l_sw, man_cb_sw}),
        .q(sync_q)
    );

    // Split synchronised vector
    assign {tune_s, key_s, mag_s, phase_s, manual_s, r12_bad_s, r5_bad_s, pwr_off_s, retune_s,
            man_ca_s, man_l_s, man_cb_s} = sync_q;

    // True when all bits of a bank of width w are set
    function automatic logic bank_full(input logic [10:0] v, input logic [3:0] w);
        logic [10:0] m;
        m = 11'((12'h001 << w) - 12'h001);
        return (v & m) == m;
    endfunction : bank_full

    // Edge memory of tune, fault and manual lines
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tune_d_reg <= 1'b0;
            fault_d_reg <= 1'b0;
            manual_d_reg <= 1'b0;
        end
        else
        begin
            tune_d_reg <= tune_s;
            fault_d_reg <= fault_next;
            manual_d_reg <= manual_s;
        end
    end

    // R10: tune feeds sequencer
    assign tune_rise = tune_s & ~tune_d_reg;

    // Relay settle timer; restarted by every bank change so the detectors
    // are never read while contacts are still bouncing
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            cnt_reg <= 24'h00_0000;
        end
        else if (kick_reg)
        begin
            cnt_reg <= 24'(SETTLE_CYC - 1);
        end
        else if (cnt_reg != 24'h00_0000)
        begin
            cnt_reg <= cnt_reg - 24'h00_0001;
        end
    end

    assign settled = (cnt_reg == 24'h00_0000) && !kick_reg;

    // Tuning sequencer; manual mode halts it, a new tune restarts from zero
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg <= ATS_IDLE;
            ca_reg <= '0;
            l_reg <= '0;
            cb_reg <= '0;
            sweep_l_reg <= 1'b0;
            start_ph_reg <= 1'b0;
            use_cb_reg <= 1'b0;
            kick_reg <= 1'b0;
            done_p_reg <= 1'b0;
            fail_p_reg <= 1'b0;
        end
        else
        begin
            kick_reg <= 1'b0;
            done_p_reg <= 1'b0;
            fail_p_reg <= 1'b0;
            if (manual_s)
            begin
                state_reg <= ATS_IDLE;
            end
            else if (tune_rise)
            begin
                state_reg <= ATS_START;
                ca_reg <= '0;
                l_reg <= '0;
                cb_reg <= '0;
                kick_reg <= 1'b1;
            end
            else
            begin
                case (state_reg)
                    ATS_START:
                    begin
                        if (settled)
                        begin
                            // R2: phase high is inductive
                            start_ph_reg <= phase_s;
                            sweep_l_reg <= ~phase_s;
                            // R4: capacitive sweeps inductors from smallest
                            if (!phase_s)
                                l_reg <= 11'h001;
                            else
                                cb_reg <= 7'h01;
                            kick_reg <= 1'b1;
                            state_reg <= ATS_SWEEP;
                        end
                    end
                    ATS_SWEEP:
                    begin
                        if (settled)
                        begin
                            if (phase_s != start_ph_reg)
                            begin
                                // R1: magnitude high is above 50 ohm
                                use_cb_reg <= mag_s;
                                // R5: bank chosen by sampled magnitude
                                if (mag_s)
                                begin
                                    if (sweep_l_reg)
                                        cb_reg <= 7'h01;
                                end
                                else
                                begin
                                    ca_reg <= 8'h01;
                                    cb_reg <= '0;
                                end
                                kick_reg <= 1'b1;
                                state_reg <= ATS_MATCH;
                            end
                            else if (sweep_l_reg ? bank_full(l_reg, 4'hB) : bank_full(11'(cb_reg), 4'h7))
                            begin
                                fail_p_reg <= 1'b1;
                                state_reg <= ATS_FAIL;
                            end
                            else
                            begin
                                // R6: inductive sweeps antenna-side caps
                                if (sweep_l_reg)
                                    l_reg <= l_reg + 11'h001;
                                else
                                    cb_reg <= cb_reg + 7'h01;
                                kick_reg <= 1'b1;
                            end
                        end
                    end
                    ATS_MATCH:
                    begin
                        if (settled)
                        begin
                            // R3: done when reflection under threshold
                            if (refl_level < thresh_reg)
                            begin
                                done_p_reg <= 1'b1;
                                state_reg <= ATS_DONE;
                            end
                            else if (use_cb_reg ? !bank_full(11'(cb_reg), 4'h7) : !bank_full(11'(ca_reg), 4'h8))
                            begin
                                if (use_cb_reg)
                                    cb_reg <= cb_reg + 7'h01;
                                else
                                    ca_reg <= ca_reg + 8'h01;
                                kick_reg <= 1'b1;
                            end
                            else if (!bank_full(l_reg, 4'hB))
                            begin
                                // Capacitor range exhausted: next inductor step
                                if (use_cb_reg)
                                    cb_reg <= 7'h01;
                                else
                                    ca_reg <= 8'h01;
                                l_reg <= l_reg + 11'h001;
                                kick_reg <= 1'b1;
                            end
                            else
                            begin
                                fail_p_reg <= 1'b1;
                                state_reg <= ATS_FAIL;
                            end
                        end
                    end
                    default:
                    begin
                        state_reg <= state_reg;
                    end
                endcase
            end
        end
    end

    // R16: ready cleared by new tune or manual
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ready_out <= 1'b0;
        else if (tune_rise || manual_s)
            ready_out <= 1'b0;
        else if (done_p_reg)
            ready_out <= 1'b1;
    end

    // R12: fault from rails and power switch
    assign fault_next = r12_bad_s || r5_bad_s || pwr_off_s;

    // Link outputs and relay drivers, all registered
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            fault_out <= 1'b0;
            manual_out <= 1'b0;
            exciter_retune <= 1'b0;
            ant_relay <= 1'b0;
            atten_on <= 1'b0;
        end
        else
        begin
            fault_out <= fault_next;
            // R13: manual mode indication
            manual_out <= manual_s;
            // R14: retune switch passed on
            exciter_retune <= retune_s;
            // R10: key drives antenna relay
            ant_relay <= key_s;
            // R11: attenuator during tuning
            atten_on <= (state_reg == ATS_START) || (state_reg == ATS_SWEEP) || (state_reg == ATS_MATCH);
        end
    end

    // R7: bank relays and LEDs, R8 and R9 alike
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            tx_side_cond_bank <= '0;
            inductor_bank <= '0;
            antenna_side_cond_bank <= '0;
        end
        else
        begin
            // R13: local switches win in manual
            tx_side_cond_bank <= manual_s ? man_ca_s : ca_reg;
            inductor_bank <= manual_s ? man_l_s : l_reg;
            antenna_side_cond_bank <= manual_s ? man_cb_s : cb_reg;
        end
    end

    // Interrupt events and write-one-to-clear; a new event beats the clear
    assign irq_ev = {manual_s ^ manual_d_reg, fault_next & ~fault_d_reg, fail_p_reg, done_p_reg};
    assign irq_clr = (wr_stb && addr == `ATS_OFS_IRQ_STAT) ? wdata[3:0] : 4'h0;

    always_ff @(posedge clk)
    begin
        if (!nrst)
            irq_stat_reg <= 4'h0;
        else
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Writable registers
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            thresh_reg <= `ATS_RST_THRESH;
            irq_mask_reg <= `ATS_RST_MASK;
        end
        else if (wr_stb)
        begin
            if (addr == `ATS_OFS_THRESH)
                thresh_reg <= wdata[7:0];
            else if (addr == `ATS_OFS_IRQ_MASK)
                irq_mask_reg <= wdata[3:0];
        end
    end

    // Read data in the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata <= 32'h0000_0000;
        else if (!rd_stb)
            rdata <= 32'h0000_0000;
        else if (addr == `ATS_OFS_THRESH)
            rdata <= {24'h00_0000, thresh_reg};
        else if (addr == `ATS_OFS_STATUS)
            rdata <= {21'h00_0000, state_reg, 1'b0, phase_s, mag_s, manual_s, fault_out,
                      state_reg == ATS_FAIL, atten_on, ready_out};
        else if (addr == `ATS_OFS_IRQ_STAT)
            rdata <= {28'h000_0000, irq_stat_reg};
        else if (addr == `ATS_OFS_IRQ_MASK)
            rdata <= {28'h000_0000, irq_mask_reg};
        else if (addr == `ATS_OFS_BANKS)
            rdata <= {6'h00, antenna_side_cond_bank, inductor_bank, tx_side_cond_bank};
        else
            rdata <= 32'h0000_0000;
    end

    default clocking cb_clk @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_flip;
        state_reg == ATS_SWEEP && settled && phase_s != start_ph_reg && !manual_s && !tune_rise;
    endsequence

    a_ready_cause: assert property ($rose(ready_out) |-> $past(state_reg, 2) == ATS_MATCH) // R3
        else $error("ready rose without a match");
    a_mag_sample: assert property (s_flip |=> use_cb_reg == $past(mag_s)) // R1
        else $error("magnitude not sampled at flip");
    a_phase_pick: assert property (state_reg == ATS_START && settled && !manual_s && !tune_rise
        |=> sweep_l_reg == !$past(phase_s)) // R2
        else $error("wrong sweep for phase");
    a_l_sweep: assert property (state_reg == ATS_SWEEP && sweep_l_reg |-> ca_reg == '0 && cb_reg == '0) // R4
        else $error("caps set during inductor sweep");
    a_cb_sweep: assert property (state_reg == ATS_SWEEP && !sweep_l_reg |-> ca_reg == '0 && l_reg == '0) // R6
        else $error("other banks set during cap sweep");
    a_bank_pick: assert property (state_reg == ATS_MATCH |-> (use_cb_reg ? ca_reg == '0 : cb_reg == '0)) // R5
        else $error("both capacitor banks in use");
    a_ready_drop: assert property (tune_rise |=> !ready_out [*2]) // R16
        else $error("ready not dropped on tune");
    a_atten_tune: assert property (tune_rise && !manual_s |=> ##1 atten_on) // R11
        else $error("attenuator missing while tuning");
    a_fault_pwr: assert property (pwr_off_s |=> fault_out) // R12
        else $error("fault missing with power off");
    a_manual_sel: assert property (manual_s |=> manual_out && inductor_bank == $past(man_l_s)) // R13
        else $error("manual selection not applied");
    a_retune_pass: assert property (retune_s |=> exciter_retune) // R14
        else $error("retune not passed");
endmodule : ats_top
`default_nettype wire

// ---- verif/ats_main_unit.sv ----
// Main unit link model: raises the tune request and holds it until ready returns
`timescale 1ns/1ps
`default_nettype none
module ats_main_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic ready_out,
    output logic tune_in
);
    logic saw_low_reg;

    // drive tune request
    // Tune stays high until ready has dropped and come back, so one request gives one rise
    always @(posedge clk)
    begin
        if (!nrst)
        begin
            tune_in <= 1'b0;
            saw_low_reg <= 1'b0;
        end
        else if (start)
        begin
            tune_in <= 1'b1;
            saw_low_reg <= 1'b0;
        end
        else if (tune_in && !ready_out)
            saw_low_reg <= 1'b1;
        else if (tune_in && saw_low_reg && ready_out)
            tune_in <= 1'b0;
    end
endmodule : ats_main_unit
`default_nettype wire

// ---- verif/antenna_tuner_sequencer_tb.sv ----
// Self-checking bench of the antenna tuner sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ats_params.svh"
module antenna_tuner_sequencer_tb;
    typedef struct packed {logic ind; logic mag; logic [4:0] pins; logic [25:0] banks; logic [2:0] outs;} ats_row_t;
    logic clk, nrst, tune_in, key_in, mag_above_in, phase_ind_in, manual_sw, rail12_ok, rail5_ok, pwr_sw_on;
    logic retune_sw, wr_stb, rd_stb, start, ind_start, mag_hi, irq;
    logic ready_out, fault_out, manual_out, exciter_retune, ant_relay, atten_on;
    logic [`ATS_CA_W-1:0] man_ca_sw, tx_side_cond_bank;
    logic [`ATS_L_W-1:0] man_l_sw, inductor_bank;
    logic [`ATS_CB_W-1:0] man_cb_sw, antenna_side_cond_bank;
    logic [7:0] refl_level, addr;
    logic [31:0] wdata, rdata;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    // Pins are {rail12, rail5, power, retune, key}; outs are {fault, retune, relay}
    ats_row_t rows [4] = '{
        '{1'b0, 1'b0, 5'h1E, 26'h000_0302, 3'h2},
        '{1'b0, 1'b1, 5'h0D, 26'h010_0300, 3'h5},
        '{1'b1, 1'b1, 5'h17, 26'h028_0000, 3'h7},
        '{1'b1, 1'b0, 5'h18, 26'h000_0002, 3'h4}};

    // Settle must outlast the antenna model lag plus the four-flop phase path, else stale phase is read
    ats_top #(.SETTLE_CYC(8)) ats_top_inst (.clk(clk), .nrst(nrst), .tune_in(tune_in), .key_in(key_in),
        .mag_above_in(mag_above_in), .phase_ind_in(phase_ind_in), .manual_sw(manual_sw), .rail12_ok(rail12_ok),
        .rail5_ok(rail5_ok), .pwr_sw_on(pwr_sw_on), .retune_sw(retune_sw), .man_ca_sw(man_ca_sw),
        .man_l_sw(man_l_sw), .man_cb_sw(man_cb_sw), .refl_level(refl_level), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ready_out(ready_out), .fault_out(fault_out),
        .manual_out(manual_out), .exciter_retune(exciter_retune), .ant_relay(ant_relay), .atten_on(atten_on),
        .tx_side_cond_bank(tx_side_cond_bank), .inductor_bank(inductor_bank),
        .antenna_side_cond_bank(antenna_side_cond_bank), .irq(irq));
    ats_main_unit ats_main_unit_inst (.clk(clk), .nrst(nrst), .start(start), .ready_out(ready_out),
        .tune_in(tune_in));

    // Clock at 20 MHz
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Antenna model: phase turns in the swept bank at the third step, one cell per path matches
    // Mismatch level equals the reset threshold, so a non-strict compare would stop too early
    always @(posedge clk)
    begin
        phase_ind_in <= ind_start ? (antenna_side_cond_bank < 7'h03) : (inductor_bank >= 11'h003);
        mag_above_in <= mag_hi;
        refl_level <= (tx_side_cond_bank == 8'h02 || antenna_side_cond_bank == 7'h05 ||
            (antenna_side_cond_bank == 7'h02 && inductor_bank == 11'h003)) ? 8'h0F : 8'h10;
    end

    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        #1;
    end
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    begin
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 check("register read", exp, rdata);
    end
    endtask : reg_rd

    // One tune request, checked while running and at the end
    task automatic run_tune();
        int i;
    begin
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        // Poll just after each edge so the value launched there has settled
        #1;
        for (i = 0; i < 20 && atten_on !== 1'b1; i++)
            #50;
        check("atten while tuning", 32'h0000_0001, 32'(atten_on));
        check("ready while tuning", 32'h0000_0000, 32'(ready_out));
        for (i = 0; i < 3000 && tune_in === 1'b1; i++)
            #50;
        check("ready after match", 32'h0000_0001, 32'(ready_out));
        check("atten after match", 32'h0000_0000, 32'(atten_on));
    end
    endtask : run_tune

    task automatic give_verdict();
    begin
        $display("errors %0d of %0d checks", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask : give_verdict

    // Main sequence
    initial
    begin
        {nrst, key_in, manual_sw, retune_sw, wr_stb, rd_stb, start, ind_start, mag_hi} = '0;
        {rail12_ok, rail5_ok, pwr_sw_on} = 3'h7;
        {man_ca_sw, man_l_sw, man_cb_sw, addr, wdata} = '0;
        repeat (6) @(posedge clk);
        #1 check("outputs in reset", 32'h0000_0000, 32'({ready_out, atten_on, manual_out, tx_side_cond_bank}));
        nrst <= 1'b1;
        reg_rd(`ATS_OFS_THRESH, 32'h0000_0010);
        check("no fault after reset", 32'h0000_0000, 32'(fault_out));
        reg_rd(`ATS_OFS_IRQ_MASK, 32'h0000_0000);
        reg_rd(8'h14, 32'h0000_0000);
        // Ordinary cases: the four start-phase and magnitude paths, then link lines
        foreach (rows[k])
        begin
            {rail12_ok, rail5_ok, pwr_sw_on, retune_sw, key_in} <= 5'h1C;
            ind_start <= rows[k].ind;
            mag_hi <= rows[k].mag;
            repeat (8) @(posedge clk);
            run_tune();
            check("banks", 32'(rows[k].banks),
                32'({antenna_side_cond_bank, inductor_bank, tx_side_cond_bank}));
            reg_rd(`ATS_OFS_BANKS, 32'(rows[k].banks));
            {rail12_ok, rail5_ok, pwr_sw_on, retune_sw, key_in} <= rows[k].pins;
            repeat (8) @(posedge clk);
            #1 check("link lines", 32'(rows[k].outs), 32'({fault_out, exciter_retune, ant_relay}));
        end
        // Sticky events, mask and write-one clear
        reg_rd(`ATS_OFS_IRQ_STAT, 32'h0000_0005);
        check("irq masked", 32'h0000_0000, 32'(irq));
        reg_wr(`ATS_OFS_IRQ_MASK, 32'h0000_0001);
        check("irq unmasked", 32'h0000_0001, 32'(irq));
        reg_wr(`ATS_OFS_IRQ_STAT, 32'h0000_0001);
        check("irq cleared", 32'h0000_0000, 32'(irq));
        reg_rd(`ATS_OFS_IRQ_STAT, 32'h0000_0004);
        reg_wr(`ATS_OFS_IRQ_MASK, 32'h0000_0004);
        check("irq fault", 32'h0000_0001, 32'(irq));
        // Second reset restores the threshold and drops ready
        reg_wr(`ATS_OFS_THRESH, 32'h0000_0020);
        reg_rd(`ATS_OFS_THRESH, 32'h0000_0020);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check("ready in reset", 32'h0000_0000, 32'({ready_out, irq, inductor_bank}));
        nrst <= 1'b1;
        reg_rd(`ATS_OFS_THRESH, 32'h0000_0010);
        // Manual switch in mid-tune takes over the banks
        {rail12_ok, rail5_ok, pwr_sw_on} <= 3'h7;
        {man_ca_sw, man_l_sw, man_cb_sw} <= {8'hA5, 11'h5A3, 7'h3C};
        repeat (8) @(posedge clk);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (12) @(posedge clk);
        manual_sw <= 1'b1;
        repeat (10) @(posedge clk);
        #1 check("manual lines", 32'h0000_0004, 32'({manual_out, ready_out, atten_on}));
        check("manual banks", 32'({man_cb_sw, man_l_sw, man_ca_sw}),
            32'({antenna_side_cond_bank, inductor_bank, tx_side_cond_bank}));
        give_verdict();
    end
endmodule : antenna_tuner_sequencer_tb
`default_nettype wire
